// ---- rpc_top.sv ----
// Receive payload per-channel control for one framer
`default_nettype none
module rpc_top
  import rpc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire rpc_pkg::rpc_bus_t bus,
  output logic [7:0] bus_rdata,
  input wire logic in_valid,
  output logic in_ready,
  input wire rpc_pkg::rpc_word_t in_word,
  input wire logic pattern_gen_mode,
  input wire logic [7:0] pattern_gen_byte,
  output logic pattern_extract_valid,
  output logic [7:0] pattern_extract_byte,
  output logic out_valid,
  input wire logic out_ready,
  output rpc_pkg::rpc_word_t system_rx_data_out
);
  import rpc_pkg::*;

  // ------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------
  function automatic logic addr_valid(input logic [6:0] a);
    addr_valid = (a >= IND_ADDR_FIRST) && (a <= IND_ADDR_LAST);
  endfunction

  function automatic logic [7:0] invert_byte(input logic [7:0] d,
                                             input logic inv,
                                             input logic msb);
    logic [7:0] mask;
    mask = {inv ^ msb, {7{inv}}};
    invert_byte = d ^ mask;
  endfunction

  // ------------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------------
  logic per_channel_enable;
  logic [7:0] address_control;
  logic [7:0] data_buffer;
  logic [2:0] acc_count;
  logic [2:0] mw_phase;
  rpc_acc_state_t acc_state;
  // Indirect registers have no reset value, so no reset on the array
  logic [7:0] ind_mem [NUM_INDIRECT];

  wire busy = (acc_state == ACC_BUSY);
  wire wr_config = bus.wr && (bus.addr == OFS_PAYLOAD_CTRL_CONFIG);
  wire wr_addr_ctrl = bus.wr && (bus.addr == OFS_INDIRECT_ADDRESS_CONTROL);
  wire wr_data_buf = bus.wr && (bus.addr == OFS_INDIRECT_DATA_BUFFER);
  wire [6:0] req_addr = bus.wdata[6:0];
  // Address/control writes while busy are dropped whole; config writes still land, and data buffer writes too except on the edge a read completes
  wire accept_addr_ctrl = wr_addr_ctrl && !busy;
  wire start_access = accept_addr_ctrl && addr_valid(req_addr);
  wire finish_access = busy && (acc_count == 3'h0);
  wire acc_read = address_control[POS_ACCESS_DIRECTION];
  wire [6:0] acc_index = address_control[6:0] - IND_ADDR_FIRST;

  // ------------------------------------------------------------------
  // Register read mux
  // ------------------------------------------------------------------
  logic [7:0] next_rdata;
  assign next_rdata =
    (bus.addr == OFS_PAYLOAD_CTRL_CONFIG) ?
      {7'h00, per_channel_enable} :
    (bus.addr == OFS_INDIRECT_ACCESS_STATUS) ?
      {busy, 7'h00} :
    (bus.addr == OFS_INDIRECT_ADDRESS_CONTROL) ? address_control :
    (bus.addr == OFS_INDIRECT_DATA_BUFFER) ? data_buffer : 8'h00;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bus_rdata <= 8'h00;
    end else if (ce && bus.rd) begin
      bus_rdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------------
  // Direct registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      per_channel_enable <= RST_PER_CHANNEL_ENABLE;
      address_control <= RST_ADDRESS_CONTROL;
    end else if (ce) begin
      if (wr_config) begin
        per_channel_enable <= bus.wdata[POS_PER_CHANNEL_ENABLE];
      end
      if (accept_addr_ctrl) begin
        address_control <= bus.wdata;
      end
    end
  end

  // The read result lands on the same edge that clears busy
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      data_buffer <= RST_DATA_BUFFER;
    end else if (ce) begin
      if (finish_access && acc_read) begin
        data_buffer <= ind_mem[acc_index];
      end else if (wr_data_buf) begin
        data_buffer <= bus.wdata;
      end
    end
  end

  // ------------------------------------------------------------------
  // Indirect access sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      acc_state <= ACC_IDLE;
      acc_count <= 3'h0;
    end else if (ce) begin
      case (acc_state)
        ACC_IDLE: begin
          if (start_access) begin
            acc_state <= ACC_BUSY;
            acc_count <= ACCESS_LAST;
          end
        end
        ACC_BUSY: begin
          if (finish_access) begin
            acc_state <= ACC_IDLE;
          end else begin
            acc_count <= acc_count - 3'h1;
          end
        end
        default: begin
          acc_state <= ACC_IDLE;
        end
      endcase
    end
  end

  // Write data is taken at completion; the host must not touch it sooner
  always_ff @(posedge mclk) begin
    if (ce && finish_access && !acc_read) begin
      ind_mem[acc_index] <= data_buffer;
    end
  end

  // ------------------------------------------------------------------
  // Per-channel lookup
  // ------------------------------------------------------------------
  wire in_chan_ok = (in_word.chan >= 5'h01) &&
                    (in_word.chan <= 5'(NUM_CHANNELS));
  wire [6:0] chan_off = {2'b00, in_word.chan} - 7'h01;
  wire [6:0] cfg_idx = (IND_BASE_CONFIG - IND_ADDR_FIRST) + chan_off;
  wire [6:0] trk_idx = (IND_BASE_TRUNK - IND_ADDR_FIRST) + chan_off;
  wire [7:0] chan_cfg = ind_mem[cfg_idx];
  wire [7:0] chan_trunk = ind_mem[trk_idx];
  wire active = per_channel_enable && in_chan_ok;

  wire sel_test = active && chan_cfg[POS_TEST];
  wire sel_extract = sel_test && !pattern_gen_mode;
  wire sel_trunk = active && chan_cfg[POS_TRUNK_CODE_ENABLE];
  wire sel_mw = active && chan_cfg[POS_MILLIWATT_ENABLE];
  wire sel_pattern = sel_test && pattern_gen_mode;
  wire sel_invert = active;
  wire sel_fix = active && chan_cfg[POS_FIX] && in_word.sig_frame;

  // ------------------------------------------------------------------
  // Output byte selection
  // ------------------------------------------------------------------
  wire [7:0] mw_byte = MILLIWATT_SEQ[8*(7-int'(mw_phase)) +: 8];
  wire [7:0] inv_byte = invert_byte(in_word.data,
                                    chan_cfg[POS_INVERT],
                                    chan_cfg[POS_MSB_INVERT_SELECT]);
  wire replaced = sel_trunk || sel_mw || sel_pattern;
  // Replaced or extracted bytes leave untouched by lower operations
  wire [7:0] sel_byte =
    sel_extract ? in_word.data :
    sel_trunk ? chan_trunk :
    sel_mw ? mw_byte :
    sel_pattern ? pattern_gen_byte :
    sel_invert ? inv_byte : in_word.data;
  wire [7:0] fixed_byte = {sel_byte[7:1],
                           chan_cfg[POS_FORCED_SIGNAL_LEVEL]};
  wire do_fix = sel_fix && !sel_extract && !replaced;

  rpc_word_t next_word;
  assign next_word = '{data: (do_fix ? fixed_byte : sel_byte),
                       chan: in_word.chan,
                       sig_frame: in_word.sig_frame};

  wire take = in_valid && in_ready;

  // ------------------------------------------------------------------
  // Milliwatt phase and pattern detector tap
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mw_phase <= RST_MW_PHASE;
      pattern_extract_valid <= 1'b0;
      pattern_extract_byte <= 8'h00;
    end else if (ce) begin
      // Phase steps once per frame, after the last channel
      if (take && (in_word.chan == 5'(NUM_CHANNELS))) begin
        mw_phase <= mw_phase + 3'h1;
      end
      pattern_extract_valid <= take && sel_extract;
      if (take && sel_extract) begin
        pattern_extract_byte <= in_word.data;
      end
    end
  end

  // ------------------------------------------------------------------
  // Output buffer
  // ------------------------------------------------------------------
  rpc_buf2 #(
    .WIDTH($bits(rpc_word_t))
  ) u_buf (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(next_word),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(system_rx_data_out)
  );
endmodule
`default_nettype wire

// ---- rpc_pkg.sv ----
// Package of constants and types for the receive payload control block
`default_nettype none
package rpc_pkg;
  // ------------------------------------------------------------------
  // Direct register offsets and reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_PAYLOAD_CTRL_CONFIG = 8'h50;
  localparam logic [7:0] OFS_INDIRECT_ACCESS_STATUS = 8'h51;
  localparam logic [7:0] OFS_INDIRECT_ADDRESS_CONTROL = 8'h52;
  localparam logic [7:0] OFS_INDIRECT_DATA_BUFFER = 8'h53;
  localparam logic [7:0] RST_ADDRESS_CONTROL = 8'h00;
  localparam logic [7:0] RST_DATA_BUFFER = 8'h00;
  localparam logic RST_PER_CHANNEL_ENABLE = 1'b0;
  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int POS_PER_CHANNEL_ENABLE = 0;
  localparam int POS_BUSY = 7;
  localparam int POS_ACCESS_DIRECTION = 7;
  localparam int POS_INVERT = 7;
  localparam int POS_TRUNK_CODE_ENABLE = 6;
  localparam int POS_MILLIWATT_ENABLE = 5;
  localparam int POS_MSB_INVERT_SELECT = 4;
  localparam int POS_TEST = 3;
  localparam int POS_FIX = 1;
  localparam int POS_FORCED_SIGNAL_LEVEL = 0;
  localparam int POS_SIGNAL_BIT = 0;
  // ------------------------------------------------------------------
  // Indirect space layout
  // ------------------------------------------------------------------
  localparam int NUM_CHANNELS = 24;
  localparam int NUM_INDIRECT = 72;
  localparam logic [6:0] IND_ADDR_FIRST = 7'h01;
  localparam logic [6:0] IND_ADDR_LAST = 7'h48;
  localparam logic [6:0] IND_BASE_CONFIG = 7'h01;
  localparam logic [6:0] IND_BASE_TRUNK = 7'h19;
  localparam logic [6:0] IND_BASE_SIGNAL = 7'h31;
  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int ACCESS_TIME_NS = 640;
  localparam int ACCESS_CYCLES =
    (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] ACCESS_LAST = 3'(ACCESS_CYCLES - 1);
  // ------------------------------------------------------------------
  // Milliwatt sequence, one byte per frame
  // ------------------------------------------------------------------
  localparam logic [63:0] MILLIWATT_SEQ = 64'h1E0B_0B1E_9E8B_8B9E;
  localparam logic [2:0] RST_MW_PHASE = 3'h0;
  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] data;
    logic [4:0] chan;
    logic sig_frame;
  } rpc_word_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rpc_bus_t;
  typedef enum logic {ACC_IDLE, ACC_BUSY} rpc_acc_state_t;
endpackage
`default_nettype wire

// ---- rpc_buf2.sv ----
// Two-entry buffer with registered outputs on both sides
`default_nettype none
module rpc_buf2 #(
  parameter int WIDTH = 14
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] spare_data;
  wire head_free = out_ready || !out_valid;

  // Ready low marks the spare slot full; held in its own flop so that
  // the ready output leaves straight from a register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      out_valid <= 1'b0;
      out_data <= '0;
      in_ready <= 1'b1;
      spare_data <= '0;
    end else if (ce) begin
      if (head_free) begin
        if (!in_ready) begin
          out_data <= spare_data;
          out_valid <= 1'b1;
          in_ready <= 1'b1;
        end else begin
          out_data <= in_data;
          out_valid <= in_valid;
        end
      end else if (in_valid && in_ready) begin
        spare_data <= in_data;
        in_ready <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- rpc_monitor.sv ----
// Assertion checker for the receive payload control block
`default_nettype none
module rpc_monitor
  import rpc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire rpc_pkg::rpc_bus_t bus,
  input wire logic [7:0] bus_rdata,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire rpc_pkg::rpc_word_t in_word,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire rpc_pkg::rpc_word_t system_rx_data_out
);
  import rpc_pkg::*;
  logic [2:0] cnt;
  logic en;
  logic [7:0] ac;
  wire rd = ce && bus.rd;
  wire go = ce && bus.wr && bus.addr == OFS_INDIRECT_ADDRESS_CONTROL
    && cnt == 3'h0;
  wire vld = bus.wdata[6:0] >= IND_ADDR_FIRST
    && bus.wdata[6:0] <= IND_ADDR_LAST;
  // The model count is nonzero exactly while the design reports busy
  wire bsy = cnt != 3'h0;
  wire take = in_valid && in_ready && ce;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt <= 3'h0;
      en <= 1'b0;
      ac <= 8'h00;
    end else if (ce) begin
      if (cnt != 3'h0) cnt <= cnt - 3'h1;
      if (go) ac <= bus.wdata;
      if (go && vld) cnt <= 3'(ACCESS_CYCLES);
      if (bus.wr && bus.addr == OFS_PAYLOAD_CTRL_CONFIG) en <= bus.wdata[0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  chk_busy_flag:
    assert property (rd && bus.addr == OFS_INDIRECT_ACCESS_STATUS
      |=> bus_rdata[POS_BUSY] == $past(bsy)) else $error("busy flag");
  chk_busy_ignore:
    assert property (rd && bus.addr == OFS_INDIRECT_ADDRESS_CONTROL
      |=> bus_rdata == $past(ac)) else $error("address control");
  chk_enable_bit:
    assert property (rd && bus.addr == OFS_PAYLOAD_CTRL_CONFIG
      |=> bus_rdata[0] == $past(en)) else $error("enable bit");
  chk_unmapped_zero:
    assert property (rd && (bus.addr < OFS_PAYLOAD_CTRL_CONFIG
      || bus.addr > OFS_INDIRECT_DATA_BUFFER) |=> bus_rdata == 8'h00)
      else $error("unmapped read");
  chk_rdata_hold:
    assert property (!rd |=> $stable(bus_rdata)) else $error("rdata moved");
  chk_out_hold:
    assert property (out_valid && !out_ready
      |=> out_valid && $stable(system_rx_data_out)) else $error("out hold");
  chk_buffer_full:
    assert property (take && out_valid && !out_ready |=> !in_ready)
      else $error("buffer full");
  chk_out_follow:
    assert property (take && !out_valid |=> out_valid) else $error("latency");
  chk_bypass_word:
    assert property (take && !en && !out_valid
      |=> system_rx_data_out == $past(in_word)) else $error("bypass");
endmodule
`default_nettype wire

// ---- rpc_sink.sv ----
// Backplane receiver model that stalls in bursts
`default_nettype none
module rpc_sink
  import rpc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic out_valid,
  output logic out_ready,
  input wire rpc_pkg::rpc_word_t system_rx_data_out
);
  logic [3:0] cnt;
  rpc_word_t got[$];
  // Four stalled cycles in sixteen, long enough to fill the buffer
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt <= 4'h0;
      out_ready <= 1'b0;
    end else begin
      if (out_valid && out_ready) got.push_back(system_rx_data_out);
      cnt <= cnt + 4'h1;
      out_ready <= cnt[3:2] != 2'b11;
    end
  end
endmodule
`default_nettype wire

// ---- rpc_tb_top.sv ----
// Testbench for the receive payload control block
`default_nettype none
module rpc_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rpc_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  rpc_bus_t bus = '0;
  logic [7:0] bus_rdata;
  logic in_valid = 1'b0;
  logic in_ready;
  rpc_word_t in_word = '0;
  logic pattern_gen_mode = 1'b0;
  logic [7:0] pattern_gen_byte = 8'h00;
  logic pattern_extract_valid;
  logic [7:0] pattern_extract_byte;
  logic out_valid;
  logic out_ready;
  rpc_word_t system_rx_data_out;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  int px_count = 0;
  logic [7:0] px_byte = 8'h00;
  logic [7:0] r;
  logic [7:0] cfg [1:8] = '{8'h00, 8'h10, 8'h80, 8'h90, 8'hC0, 8'h20,
    8'h60, 8'h03};
  always #50 mclk = ~mclk;
  rpc_top uut (.mclk, .reset, .ce, .bus, .bus_rdata, .in_valid, .in_ready,
    .in_word, .pattern_gen_mode, .pattern_gen_byte, .pattern_extract_valid,
    .pattern_extract_byte, .out_valid, .out_ready, .system_rx_data_out);
  rpc_sink sink (.mclk, .reset, .out_valid, .out_ready,
    .system_rx_data_out);
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus.wr = 1'b1;
    bus.addr = a;
    bus.wdata = d;
    @(negedge mclk);
    bus.wr = 1'b0;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bus.rd = 1'b1;
    bus.addr = a;
    @(negedge mclk);
    bus.rd = 1'b0;
    @(negedge mclk);
    d = bus_rdata;
  endtask
  task automatic wait_idle;
    logic [7:0] s;
    int n;
    n = 0;
    do begin
      rd(OFS_INDIRECT_ACCESS_STATUS, s);
      n++;
    end while (s[POS_BUSY] !== 1'b0 && n < 20);
    cmp({7'h00, s[POS_BUSY]}, 8'h00);
  endtask
  task automatic iwr(input logic [6:0] a, input logic [7:0] d);
    wr(OFS_INDIRECT_DATA_BUFFER, d);
    wr(OFS_INDIRECT_ADDRESS_CONTROL, {1'b0, a});
    wait_idle();
  endtask
  function automatic logic [7:0] expv(input int c);
    logic [7:0] f;
    logic [7:0] d;
    f = cfg[c];
    d = 8'(c * 16 + 4);
    if (f[POS_TEST] && !pattern_gen_mode) return d;
    if (f[POS_TRUNK_CODE_ENABLE]) return 8'hA0 | 8'(c);
    if (f[POS_MILLIWATT_ENABLE]) return MILLIWATT_SEQ[63:56];
    if (f[POS_TEST]) return pattern_gen_byte;
    case ({f[POS_INVERT], f[POS_MSB_INVERT_SELECT]})
      2'b01: d = d ^ 8'h80;
      2'b10: d = ~d;
      2'b11: d = d ^ 8'h7F;
      default: ;
    endcase
    if (f[POS_FIX]) d[POS_SIGNAL_BIT] = f[POS_FORCED_SIGNAL_LEVEL];
    return d;
  endfunction
  task automatic stream(input logic on);
    rpc_word_t w;
    for (int c = 1; c <= 8; c++) begin
      in_word = '{8'(c * 16 + 4), 5'(c), 1'b1};
      in_valid = 1'b1;
      while (in_ready !== 1'b1) @(negedge mclk);
      @(negedge mclk);
    end
    in_valid = 1'b0;
    for (int k = 0; k < 80 && sink.got.size() < 8; k++) @(negedge mclk);
    for (int c = 1; c <= 8; c++) begin
      w = sink.got.size() > 0 ? sink.got.pop_front() : '0;
      cmp(w.data, on ? expv(c) : 8'(c * 16 + 4));
      cmp({3'h0, w.chan}, 8'(c));
    end
  endtask
  task automatic finish_test;
    $display("failures %0d checks %0d", failures, check_count);
    if (failures == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Extraction pulses last one cycle, so they are counted as they pass
  always @(posedge mclk) begin
    if (pattern_extract_valid === 1'b1) begin
      px_count++;
      px_byte = pattern_extract_byte;
    end
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      $display("wrong value at %0t: run too long", $time);
      finish_test();
    end
  end
  initial begin
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    // Reset values, with one unmapped offset after the four registers
    for (int a = 'h50; a <= 'h54; a++) begin
      rd(8'(a), r);
      cmp(r, 8'h00);
    end
    for (int c = 1; c <= 8; c++) begin
      iwr(7'(c), cfg[c]);
      iwr(7'(c + 24), 8'hA0 | 8'(c));
    end
    stream(1'b0);
    wr(OFS_PAYLOAD_CTRL_CONFIG, 8'h01);
    rd(OFS_PAYLOAD_CTRL_CONFIG, r);
    cmp(r & 8'h01, 8'h01);
    stream(1'b1);
    // A read of channel 5 with an overwrite refused while busy
    wr(OFS_INDIRECT_ADDRESS_CONTROL, 8'h85);
    rd(OFS_INDIRECT_ACCESS_STATUS, r);
    cmp(r & 8'h80, 8'h80);
    wr(OFS_INDIRECT_ADDRESS_CONTROL, 8'h1D);
    // Clock enable low freezes the access part way through
    ce = 1'b0;
    repeat (10) @(negedge mclk);
    ce = 1'b1;
    rd(OFS_INDIRECT_ACCESS_STATUS, r);
    cmp(r & 8'h80, 8'h80);
    wait_idle();
    rd(OFS_INDIRECT_ADDRESS_CONTROL, r);
    cmp(r, 8'h85);
    rd(OFS_INDIRECT_DATA_BUFFER, r);
    cmp(r, 8'hC0);
    for (int a = 0; a < 2; a++) begin
      wr(OFS_INDIRECT_ADDRESS_CONTROL, a == 0 ? 8'h00 : 8'h49);
      rd(OFS_INDIRECT_ACCESS_STATUS, r);
      cmp(r & 8'h80, 8'h00);
    end
    // Test bit on channel 1: extraction, then pattern replacement
    cfg[1] = 8'h8B;
    iwr(7'h01, cfg[1]);
    stream(1'b1);
    cmp(8'(px_count), 8'h01);
    cmp(px_byte, 8'h14);
    pattern_gen_mode = 1'b1;
    pattern_gen_byte = 8'h5A;
    stream(1'b1);
    cmp(8'(px_count), 8'h01);
    finish_test();
  end
endmodule
bind rpc_top rpc_monitor mon (.mclk, .reset, .ce, .bus, .bus_rdata,
  .in_valid, .in_ready, .in_word, .out_valid, .out_ready,
  .system_rx_data_out);
`default_nettype wire
